// >>> hdl/tmpf_pkg.sv
// constants, register map and carrier types of the temperature formatter
package tmpf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int TEMP_W = 16;
  localparam int FRAC_W = 4;
  localparam int INT_W = TEMP_W - FRAC_W;
  localparam int RES_W = 2;
  localparam int ST_W = 8;

  // word addresses of the register file
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RESOLUTION = 4'h1;
  localparam logic [ADDR_W-1:0] REG_LOCAL_RESULT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_REMOTE_RESULT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_LOCAL_HIGH_LIM = 4'h4;
  localparam logic [ADDR_W-1:0] REG_LOCAL_LOW_LIM = 4'h5;
  localparam logic [ADDR_W-1:0] REG_REMOTE_HIGH_LIM = 4'h6;
  localparam logic [ADDR_W-1:0] REG_REMOTE_LOW_LIM = 4'h7;
  localparam logic [ADDR_W-1:0] REG_LOCAL_THERMAL_SHUTDOWN_FLAG_LIM = 4'h8;
  localparam logic [ADDR_W-1:0] REG_REMOTE_THERMAL_SHUTDOWN_FLAG_LIM = 4'h9;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hA;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hB;

  localparam int CFG_RANGE_BIT = 2;
  localparam logic RANGE_STD = 1'b0;
  localparam logic RANGE_EXT = 1'b1;

  localparam logic [RES_W-1:0] RES_HALF = 2'h0;
  localparam logic [RES_W-1:0] RES_QUARTER = 2'h1;
  localparam logic [RES_W-1:0] RES_EIGHTH = 2'h2;
  localparam logic [RES_W-1:0] RES_SIXTEENTH = 2'h3;
  localparam logic [RES_W-1:0] RES_RESET = 2'h3;
  localparam logic [FRAC_W-1:0] FMASK_HALF = 4'h8;
  localparam logic [FRAC_W-1:0] FMASK_QUARTER = 4'hC;
  localparam logic [FRAC_W-1:0] FMASK_EIGHTH = 4'hE;
  localparam logic [FRAC_W-1:0] FMASK_SIXTEENTH = 4'hF;

  // integer-degree bounds, one bit wider than the integer field
  localparam logic signed [INT_W:0] STD_MAX_INT = 13'sh007F;
  localparam logic signed [INT_W:0] EXT_OFFSET_INT = 13'sh0040;
  localparam logic signed [INT_W:0] EXT_MIN_INT = 13'sh1FC0;
  localparam logic signed [INT_W:0] EXT_MAX_INT = 13'sh00BF;
  localparam logic signed [INT_W:0] EXT_MAX_CODE = 13'sh00FF;
  localparam logic [BYTE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] STD_MAX_CODE = 8'h7F;
  localparam logic [BYTE_W-1:0] EXT_FULL_CODE = 8'hFF;
  localparam logic [BYTE_W-1:0] EXT_OFFSET_CODE = 8'h40;
  localparam logic [FRAC_W-1:0] NIB_ZERO = 4'h0;

  localparam logic [BYTE_W-1:0] LIM_HIGH_RESET = 8'h55;
  localparam logic [BYTE_W-1:0] LIM_LOW_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] LIM_THERMAL_SHUTDOWN_FLAG_RESET = 8'h55;
  localparam logic [ST_W-1:0] MASK_RESET = 8'h00;

  // status bits, shared by the mask register
  localparam int ST_LOC_HIGH = 0;
  localparam int ST_LOC_LOW = 1;
  localparam int ST_REM_HIGH = 2;
  localparam int ST_REM_LOW = 3;
  localparam int ST_LOC_THERMAL_SHUTDOWN_FLAG = 4;
  localparam int ST_REM_THERMAL_SHUTDOWN_FLAG = 5;
  localparam int ST_LOC_DONE = 6;
  localparam int ST_REM_DONE = 7;

  localparam logic CH_LOCAL = 1'b0;
  localparam logic CH_REMOTE = 1'b1;

  typedef struct packed {
    logic valid;
    logic chan;
    logic signed [TEMP_W-1:0] temp;
  } tmpf_conv_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } tmpf_avs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } tmpf_avs_rsp_t;

  typedef struct packed {
    logic range;
    logic [RES_W-1:0] res;
    logic [BYTE_W-1:0] loc_hi;
    logic [BYTE_W-1:0] loc_lo;
    logic [BYTE_W-1:0] rem_hi;
    logic [BYTE_W-1:0] rem_lo;
    logic [BYTE_W-1:0] loc_high_lim;
    logic [BYTE_W-1:0] loc_low_lim;
    logic [BYTE_W-1:0] rem_high_lim;
    logic [BYTE_W-1:0] rem_low_lim;
    logic [BYTE_W-1:0] loc_thermal_shutdown_flag_lim;
    logic [BYTE_W-1:0] rem_thermal_shutdown_flag_lim;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [1:0] alert_src;
    logic [1:0] thermal_shutdown_flag_src;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } tmpf_state_t;
endpackage

// >>> hdl/tmpf_formatter.sv
// temperature result formatter with limit comparators and register file
// Summary of operation
// [RULE1] reset selects standard range, zero to 127
// [RULE2] config bit two set selects extended range
// [RULE3] standard range: below zero gives code zero
// [RULE4] standard range: above 127 saturates at 7Fh
// [RULE5] range change applies from next conversion only
// [RULE6] extended range: code is degrees plus 64
// [RULE7] extended codes span -64 to +191 degrees
// [RULE8] extended range clamps outside codes zero..FFh
// [RULE9] limits are never reformatted on range change
// [RULE10] two bytes; high byte whole degrees
// [RULE11] low byte holds the fractional part
// [RULE12] fraction in upper nibble, truncated to step
// [RULE13] remote fraction always in sixteenths
// [RULE14] local step selected by two resolution bits
// [RULE15] high/low limit violations drive the alert flag
// [RULE16] thermal limit excess drives shutdown flag
// [RULE17] config, results, limits, status are readable
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
module tmpf_formatter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tmpf_pkg::tmpf_conv_t conv,
  input wire tmpf_pkg::tmpf_avs_req_t avs_req,
  output tmpf_pkg::tmpf_avs_rsp_t avs_rsp,
  output logic irq,
  output logic alert_out,
  output logic alert_oe_n,
  output logic thermal_shutdown_flag_out,
  output logic thermal_shutdown_flag_oe_n
);
  import tmpf_pkg::*;

  tmpf_state_t s_reg;
  tmpf_state_t s_next;
  logic req;
  logic acc;
  logic done;
  logic [FRAC_W-1:0] fmask;
  logic [TEMP_W-1:0] fmt_res;
  logic [BYTE_W-1:0] hi_new;
  logic [BYTE_W-1:0] lim_high;
  logic [BYTE_W-1:0] lim_low;
  logic [BYTE_W-1:0] lim_thermal_shutdown_flag;
  logic over;
  logic under;
  logic hot;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] st_clr;
  logic [BYTE_W-1:0] wbyte;
  logic wr_lane;

  // local step as a mask on the sixteenths nibble
  function automatic logic [FRAC_W-1:0] res_mask(
    input logic [RES_W-1:0] r
  );
    unique case (r)
      RES_HALF: res_mask = FMASK_HALF;
      RES_QUARTER: res_mask = FMASK_QUARTER;
      RES_EIGHTH: res_mask = FMASK_EIGHTH;
      RES_SIXTEENTH: res_mask = FMASK_SIXTEENTH;
    endcase
  endfunction

  // two-byte result from a signed sixteenths value
  function automatic logic [TEMP_W-1:0] fmt(
    input logic [TEMP_W-1:0] t,
    input logic ext,
    input logic [FRAC_W-1:0] m
  );
    logic signed [INT_W:0] ip;
    logic signed [INT_W:0] code;
    logic [FRAC_W-1:0] fr;
    ip = $signed({t[TEMP_W-1], t[TEMP_W-1:FRAC_W]});
    fr = t[FRAC_W-1:0] & m; // RULE12
    code = ip + EXT_OFFSET_INT; // RULE6
    if (ext == RANGE_STD) begin
      if (ip < 0) begin
        fmt = {CODE_ZERO, CODE_ZERO}; // RULE3
      end else if (ip > STD_MAX_INT) begin
        fmt = {STD_MAX_CODE, CODE_ZERO}; // RULE4
      end else begin
        fmt = {ip[BYTE_W-1:0], fr, NIB_ZERO}; // RULE10 RULE11
      end
    end else begin
      if (code < 0) begin
        fmt = {CODE_ZERO, CODE_ZERO}; // RULE8
      end else if (code > EXT_MAX_CODE) begin
        fmt = {EXT_FULL_CODE, CODE_ZERO}; // RULE8
      end else begin
        fmt = {code[BYTE_W-1:0], fr, NIB_ZERO}; // RULE7
      end
    end
  endfunction

  // read mux; unmapped words read as zero
  function automatic logic [DATA_W-1:0] rd_word(
    input logic [ADDR_W-1:0] a,
    input tmpf_state_t s
  );
    rd_word = '0;
    unique case (a)
      REG_CONFIG: rd_word[CFG_RANGE_BIT] = s.range;
      REG_RESOLUTION: rd_word[RES_W-1:0] = s.res;
      REG_LOCAL_RESULT: rd_word[2*BYTE_W-1:0] = {s.loc_hi, s.loc_lo};
      REG_REMOTE_RESULT: rd_word[2*BYTE_W-1:0] = {s.rem_hi, s.rem_lo};
      REG_LOCAL_HIGH_LIM: rd_word[BYTE_W-1:0] = s.loc_high_lim;
      REG_LOCAL_LOW_LIM: rd_word[BYTE_W-1:0] = s.loc_low_lim;
      REG_REMOTE_HIGH_LIM: rd_word[BYTE_W-1:0] = s.rem_high_lim;
      REG_REMOTE_LOW_LIM: rd_word[BYTE_W-1:0] = s.rem_low_lim;
      REG_LOCAL_THERMAL_SHUTDOWN_FLAG_LIM: rd_word[BYTE_W-1:0] = s.loc_thermal_shutdown_flag_lim;
      REG_REMOTE_THERMAL_SHUTDOWN_FLAG_LIM: rd_word[BYTE_W-1:0] = s.rem_thermal_shutdown_flag_lim;
      REG_STATUS: rd_word[ST_W-1:0] = s.status;
      REG_IRQ_MASK: rd_word[ST_W-1:0] = s.mask;
      default: rd_word = '0;
    endcase
  endfunction

  always_comb begin
    s_next = s_reg;
    req = avs_req.read | avs_req.write;
    // first cycle of a request captures read data, second completes it
    acc = req & ~s_reg.ack;
    done = req & s_reg.ack;
    s_next.ack = acc;
    if (acc && avs_req.read) begin
      s_next.rdata = rd_word(avs_req.address, s_reg); // RULE17
    end
    wbyte = avs_req.writedata[BYTE_W-1:0];
    wr_lane = done & avs_req.write & avs_req.byteenable[0];

    // format with the range in force when the conversion completes
    fmask = (conv.chan == CH_REMOTE) ? FMASK_SIXTEENTH // RULE13
                                     : res_mask(s_reg.res); // RULE14
    fmt_res = fmt(conv.temp, s_reg.range, fmask); // RULE5
    hi_new = fmt_res[TEMP_W-1:BYTE_W];
    lim_high = conv.chan ? s_reg.rem_high_lim : s_reg.loc_high_lim;
    lim_low = conv.chan ? s_reg.rem_low_lim : s_reg.loc_low_lim;
    lim_thermal_shutdown_flag = conv.chan ? s_reg.rem_thermal_shutdown_flag_lim : s_reg.loc_thermal_shutdown_flag_lim;
    // limits compare as raw codes in whatever encoding software wrote
    over = hi_new > lim_high; // RULE15
    under = hi_new < lim_low; // RULE15
    hot = hi_new > lim_thermal_shutdown_flag; // RULE16
    ev = '0;
    if (conv.valid) begin
      if (conv.chan == CH_REMOTE) begin
        s_next.rem_hi = hi_new;
        s_next.rem_lo = fmt_res[BYTE_W-1:0];
        ev[ST_REM_HIGH] = over;
        ev[ST_REM_LOW] = under;
        ev[ST_REM_THERMAL_SHUTDOWN_FLAG] = hot;
        ev[ST_REM_DONE] = 1'b1;
      end else begin
        s_next.loc_hi = hi_new;
        s_next.loc_lo = fmt_res[BYTE_W-1:0];
        ev[ST_LOC_HIGH] = over;
        ev[ST_LOC_LOW] = under;
        ev[ST_LOC_THERMAL_SHUTDOWN_FLAG] = hot;
        ev[ST_LOC_DONE] = 1'b1;
      end
      s_next.alert_src[conv.chan] = over | under; // RULE15
      s_next.thermal_shutdown_flag_src[conv.chan] = hot; // RULE16
    end

    // a status read clears only the bits it returned; new events win
    st_clr = '0;
    if (done && avs_req.read && avs_req.address == REG_STATUS) begin
      st_clr = s_reg.rdata[ST_W-1:0];
    end
    s_next.status = (s_reg.status & ~st_clr) | ev;

    if (wr_lane) begin
      unique case (avs_req.address)
        REG_CONFIG: s_next.range = wbyte[CFG_RANGE_BIT]; // RULE2 RULE9
        REG_RESOLUTION: s_next.res = wbyte[RES_W-1:0]; // RULE14
        REG_LOCAL_HIGH_LIM: s_next.loc_high_lim = wbyte;
        REG_LOCAL_LOW_LIM: s_next.loc_low_lim = wbyte;
        REG_REMOTE_HIGH_LIM: s_next.rem_high_lim = wbyte;
        REG_REMOTE_LOW_LIM: s_next.rem_low_lim = wbyte;
        REG_LOCAL_THERMAL_SHUTDOWN_FLAG_LIM: s_next.loc_thermal_shutdown_flag_lim = wbyte;
        REG_REMOTE_THERMAL_SHUTDOWN_FLAG_LIM: s_next.rem_thermal_shutdown_flag_lim = wbyte;
        REG_IRQ_MASK: s_next.mask = wbyte;
        default: s_next.ack = acc;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.range <= RANGE_STD; // RULE1
      s_reg.res <= RES_RESET;
      s_reg.loc_high_lim <= LIM_HIGH_RESET;
      s_reg.loc_low_lim <= LIM_LOW_RESET;
      s_reg.rem_high_lim <= LIM_HIGH_RESET;
      s_reg.rem_low_lim <= LIM_LOW_RESET;
      s_reg.loc_thermal_shutdown_flag_lim <= LIM_THERMAL_SHUTDOWN_FLAG_RESET;
      s_reg.rem_thermal_shutdown_flag_lim <= LIM_THERMAL_SHUTDOWN_FLAG_RESET;
      s_reg.mask <= MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_rsp = '{readdata: s_reg.rdata, waitrequest: acc};
  assign irq = |(s_reg.status & s_reg.mask);
  // open-drain pins: pulled low while the enable is low
  assign alert_out = 1'b0;
  assign alert_oe_n = ~(|s_reg.alert_src); // RULE15
  assign thermal_shutdown_flag_out = 1'b0;
  assign thermal_shutdown_flag_oe_n = ~(|s_reg.thermal_shutdown_flag_src); // RULE16

  // checks
  logic signed [INT_W:0] a_ip;
  logic a_cfg_wr;
  logic a_any_lim_wr;
  assign a_ip = $signed({conv.temp[TEMP_W-1], conv.temp[TEMP_W-1:FRAC_W]});
  assign a_cfg_wr = wr_lane && avs_req.address == REG_CONFIG;
  assign a_any_lim_wr = wr_lane && avs_req.address >= REG_LOCAL_HIGH_LIM
                        && avs_req.address <= REG_REMOTE_THERMAL_SHUTDOWN_FLAG_LIM;

  chk_range_stays_std: assert property ( // RULE1
    @(posedge clk_sys) disable iff (rst)
    s_reg.range == RANGE_STD && !a_cfg_wr |=> s_reg.range == RANGE_STD)
    else $error("range left standard without a config write");

  chk_range_set_ext: assert property ( // RULE2
    @(posedge clk_sys) disable iff (rst)
    a_cfg_wr && wbyte[CFG_RANGE_BIT] |=> s_reg.range == RANGE_EXT)
    else $error("config write did not select extended range");

  chk_std_below_zero: assert property ( // RULE3
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.range == RANGE_STD
    && a_ip < 0 |=> s_reg.loc_hi == CODE_ZERO && s_reg.loc_lo == CODE_ZERO)
    else $error("negative standard result not zero");

  chk_std_saturate: assert property ( // RULE4
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_REMOTE && s_reg.range == RANGE_STD
    && a_ip > STD_MAX_INT |=> s_reg.rem_hi == STD_MAX_CODE)
    else $error("standard result not saturated at 7Fh");

  chk_results_hold: assert property ( // RULE5
    @(posedge clk_sys) disable iff (rst)
    !conv.valid ##1 !conv.valid |-> $stable(s_reg.loc_hi)
    && $stable(s_reg.rem_hi) && $stable(s_reg.loc_lo))
    else $error("result changed without a conversion");

  chk_ext_offset: assert property ( // RULE6
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.range == RANGE_EXT
    && a_ip >= EXT_MIN_INT && a_ip <= EXT_MAX_INT
    |=> s_reg.loc_hi == $past(conv.temp[TEMP_W-5:FRAC_W]) + EXT_OFFSET_CODE)
    else $error("extended code not degrees plus 64");

  chk_ext_clamp: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_REMOTE && s_reg.range == RANGE_EXT
    && a_ip > EXT_MAX_INT |=> s_reg.rem_hi == EXT_FULL_CODE)
    else $error("extended result above range not clamped");

  chk_limits_kept: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    a_cfg_wr && !conv.valid |=> $stable(s_reg.loc_high_lim)
    && $stable(s_reg.rem_low_lim) && $stable(s_reg.loc_thermal_shutdown_flag_lim))
    else $error("limit changed on a range write");

  chk_remote_sixteenths: assert property ( // RULE13
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_REMOTE && s_reg.range == RANGE_EXT
    && a_ip >= EXT_MIN_INT && a_ip <= EXT_MAX_INT
    |=> s_reg.rem_lo == {$past(conv.temp[FRAC_W-1:0]), NIB_ZERO})
    else $error("remote fraction not full sixteenths");

  chk_local_half_step: assert property ( // RULE14
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.res == RES_HALF
    |=> s_reg.loc_lo[BYTE_W-2:0] == '0)
    else $error("local half-degree step left low bits set");

  chk_alert_drive: assert property ( // RULE15
    @(posedge clk_sys) disable iff (rst)
    conv.valid && (over || under)
    |=> !alert_oe_n && (s_reg.status & ~s_reg.mask | s_reg.status) != '0)
    else $error("limit violation did not pull alert");

  chk_thermal_shutdown_flag_drive: assert property ( // RULE16
    @(posedge clk_sys) disable iff (rst)
    conv.valid && hot |=> !thermal_shutdown_flag_oe_n [*1] ##0
    s_reg.status[$past(conv.chan) ? ST_REM_THERMAL_SHUTDOWN_FLAG : ST_LOC_THERMAL_SHUTDOWN_FLAG])
    else $error("thermal limit excess did not raise flag");

  chk_cfg_readback: assert property ( // RULE17
    @(posedge clk_sys) disable iff (rst)
    acc && avs_req.read && avs_req.address == REG_CONFIG
    |=> avs_rsp.readdata[CFG_RANGE_BIT] == $past(s_reg.range)
    && !avs_rsp.waitrequest)
    else $error("config readback wrong or late");

  chk_std_whole_deg: assert property ( // RULE10
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.range == RANGE_STD
    && a_ip >= 0 && a_ip <= STD_MAX_INT
    |=> s_reg.loc_hi == $past(conv.temp[TEMP_W-5:FRAC_W]))
    else $error("standard result not whole degrees");

  chk_low_nibble_zero: assert property ( // RULE12
    @(posedge clk_sys) disable iff (rst)
    conv.valid |=> s_reg.loc_lo[FRAC_W-1:0] == NIB_ZERO
    && s_reg.rem_lo[FRAC_W-1:0] == NIB_ZERO)
    else $error("fraction lower nibble not zero");

  chk_ext_floor: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.range == RANGE_EXT
    && a_ip < EXT_MIN_INT |=> s_reg.loc_hi == CODE_ZERO
    && s_reg.loc_lo == CODE_ZERO)
    else $error("extended result below range not clamped");

  chk_lim_write_only: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    !a_any_lim_wr |=> $stable(s_reg.loc_low_lim)
    && $stable(s_reg.rem_high_lim) && $stable(s_reg.rem_thermal_shutdown_flag_lim))
    else $error("limit changed without a limit write");

  chk_local_quarter_step: assert property ( // RULE14
    @(posedge clk_sys) disable iff (rst)
    conv.valid && conv.chan == CH_LOCAL && s_reg.res == RES_QUARTER
    |=> s_reg.loc_lo[BYTE_W-3:0] == '0)
    else $error("local quarter-degree step left low bits set");

  chk_alert_release: assert property ( // RULE15
    @(posedge clk_sys) disable iff (rst)
    conv.valid && !over && !under && !s_reg.alert_src[~conv.chan]
    |=> alert_oe_n)
    else $error("alert held after violation ended");

  chk_thermal_shutdown_flag_release: assert property ( // RULE16
    @(posedge clk_sys) disable iff (rst)
    conv.valid && !hot && !s_reg.thermal_shutdown_flag_src[~conv.chan]
    |=> thermal_shutdown_flag_oe_n)
    else $error("thermal flag held after excess ended");

  chk_wait_one_cycle: assert property ( // RULE17
    @(posedge clk_sys) disable iff (rst)
    avs_rsp.waitrequest && (avs_req.read || avs_req.write)
    |=> !avs_rsp.waitrequest)
    else $error("waitrequest held beyond one cycle");

  chk_status_cleared: assert property ( // RULE17
    @(posedge clk_sys) disable iff (rst)
    done && avs_req.read && avs_req.address == REG_STATUS && !conv.valid
    |=> (s_reg.status & $past(s_reg.rdata[ST_W-1:0])) == '0)
    else $error("status read did not clear returned bits");

  chk_status_sticky: assert property ( // RULE17
    @(posedge clk_sys) disable iff (rst)
    !(done && avs_req.read && avs_req.address == REG_STATUS)
    |=> (s_reg.status & $past(s_reg.status)) == $past(s_reg.status))
    else $error("status bit dropped without a status read");

  cov_ext_conv: cover property (
    @(posedge clk_sys) disable iff (rst)
    conv.valid && s_reg.range == RANGE_EXT);

  cov_alert: cover property (
    @(posedge clk_sys) disable iff (rst) $fell(alert_oe_n));

  cov_status_clear: cover property (
    @(posedge clk_sys) disable iff (rst)
    done && avs_req.read && avs_req.address == REG_STATUS
    && s_reg.rdata[ST_W-1:0] != '0);

  cov_std_saturate: cover property (
    @(posedge clk_sys) disable iff (rst)
    conv.valid && s_reg.range == RANGE_STD && a_ip > STD_MAX_INT);

  cov_thermal_shutdown_flag: cover property (
    @(posedge clk_sys) disable iff (rst) $fell(thermal_shutdown_flag_oe_n));
endmodule

// >>> verification/tmpf_conv_model.sv
// behavioural converter model that delivers completed conversions
`timescale 1ns/100ps
module tmpf_conv_model (
  input wire logic clk_sys,
  output tmpf_pkg::tmpf_conv_t conv
);
  import tmpf_pkg::*;
  initial begin
    conv = '0;
  end
  // one-cycle completion pulse; temp is scrambled outside the pulse
  task automatic send(input logic ch, input logic [TEMP_W-1:0] t);
    @(posedge clk_sys);
    conv <= '{valid: 1'b1, chan: ch, temp: t};
    @(posedge clk_sys);
    conv <= '{valid: 1'b0, chan: ~ch, temp: ~t};
  endtask
endmodule

// >>> verification/temp_result_formatter_tb.sv
// self-checking bench for the temperature result formatter
`timescale 1ns/100ps
module temp_result_formatter_tb;
  import tmpf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  tmpf_avs_req_t avs_req = '0;
  tmpf_avs_rsp_t avs_rsp;
  tmpf_conv_t conv;
  logic irq, alert_out, alert_oe_n, shut_out, shut_oe_n;
  int mismatches = 0;
  int checked = 0;
  logic [FRAC_W-1:0] fmask [4] = '{FMASK_HALF, FMASK_QUARTER,
    FMASK_EIGHTH, FMASK_SIXTEENTH};
  logic [7:0] rst_v [12] = '{8'h00, {6'h00, RES_RESET}, 8'h00, 8'h00,
    LIM_HIGH_RESET, LIM_LOW_RESET, LIM_HIGH_RESET, LIM_LOW_RESET,
    LIM_THERMAL_SHUTDOWN_FLAG_RESET, LIM_THERMAL_SHUTDOWN_FLAG_RESET, 8'h00, MASK_RESET};
  logic [TEMP_W-1:0] std_t [6] = '{16'h0190, 16'hFFF8, 16'h0C80,
    16'h07FF, 16'h0001, 16'h0190};
  logic [TEMP_W-1:0] ext_t [7] = '{16'h0190, 16'hFC00, 16'hF9C0,
    16'hFCE0, 16'h0BF8, 16'h0FA0, 16'h0960};

  always #5 clk_sys = ~clk_sys;

  tmpf_formatter dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .conv(conv),
    .avs_req(avs_req),
    .avs_rsp(avs_rsp),
    .irq(irq),
    .alert_out(alert_out),
    .alert_oe_n(alert_oe_n),
    .thermal_shutdown_flag_out(shut_out),
    .thermal_shutdown_flag_oe_n(shut_oe_n)
  );

  tmpf_conv_model conv_u (
    .clk_sys(clk_sys),
    .conv(conv)
  );

  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [DATA_W-1:0] got,
                         input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    q = '0;
    @(posedge clk_sys);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: d,
                 byteenable: 4'hF};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 20);
    if (avs_rsp.waitrequest !== 1'b0) begin
      mismatches++;
      conclude();
    end else begin
      q = avs_rsp.readdata;
      avs_req <= '0;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [DATA_W-1:0] q;
    access(1'b1, a, {24'h000000, d}, q);
  endtask

  task automatic rd_cmp(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    access(1'b0, a, '0, q);
    cmp_val(q, exp);
  endtask

  task automatic pins(input logic i, input logic a, input logic s);
    @(negedge clk_sys);
    cmp_pin(irq, i);
    cmp_pin(alert_oe_n, a);
    cmp_pin(shut_oe_n, s);
    cmp_pin(alert_out, 1'b0);
    cmp_pin(shut_out, 1'b0);
  endtask

  // expected result word worked out from the range and step
  function automatic logic [DATA_W-1:0] fmt(input logic ext,
      input logic [FRAC_W-1:0] fm, input logic [TEMP_W-1:0] t);
    int c;
    c = (int'(signed'(t)) >>> 4) + (ext ? 64 : 0);
    if (c < 0) return '0;
    if (!ext && c > 127) return 32'h00007F00;
    if (c > 255) return 32'h0000FF00;
    return {16'h0000, 8'(c), t[3:0] & fm, 4'h0};
  endfunction

  initial begin
    logic [DATA_W-1:0] q;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      rd_cmp(ADDR_W'(i), {24'h000000, rst_v[i]});
    end
    wr(4'hC, 8'hFF);
    rd_cmp(4'hC, 32'h00000000);
    foreach (std_t[i]) begin
      conv_u.send(CH_LOCAL, std_t[i]);
      rd_cmp(REG_LOCAL_RESULT,
             fmt(RANGE_STD, FMASK_SIXTEENTH, std_t[i]));
      conv_u.send(CH_REMOTE, std_t[i]);
      rd_cmp(REG_REMOTE_RESULT,
             fmt(RANGE_STD, FMASK_SIXTEENTH, std_t[i]));
    end
    wr(REG_LOCAL_RESULT, 8'hAA);
    rd_cmp(REG_LOCAL_RESULT, 32'h00001900);
    for (int r = 0; r < 4; r++) begin
      wr(REG_RESOLUTION, 8'(r));
      conv_u.send(CH_LOCAL, 16'h019F);
      rd_cmp(REG_LOCAL_RESULT,
             fmt(RANGE_STD, fmask[r], 16'h019F));
      conv_u.send(CH_REMOTE, 16'h019F);
      rd_cmp(REG_REMOTE_RESULT,
             fmt(RANGE_STD, FMASK_SIXTEENTH, 16'h019F));
    end
    access(1'b0, REG_STATUS, '0, q);
    wr(REG_IRQ_MASK, 8'hFF);
    conv_u.send(CH_LOCAL, 16'h05A0);
    pins(1'b1, 1'b0, 1'b0);
    rd_cmp(REG_STATUS, 32'h00000051);
    rd_cmp(REG_STATUS, 32'h00000000);
    pins(1'b0, 1'b0, 1'b0);
    wr(REG_LOCAL_LOW_LIM, 8'h30);
    wr(REG_LOCAL_THERMAL_SHUTDOWN_FLAG_LIM, 8'h70);
    conv_u.send(CH_LOCAL, 16'h0190);
    pins(1'b1, 1'b0, 1'b1);
    rd_cmp(REG_STATUS, 32'h00000042);
    conv_u.send(CH_LOCAL, 16'h0400);
    pins(1'b1, 1'b1, 1'b1);
    rd_cmp(REG_STATUS, 32'h00000040);
    wr(REG_IRQ_MASK, 8'h00);
    conv_u.send(CH_LOCAL, 16'h05A0);
    pins(1'b0, 1'b0, 1'b1);
    rd_cmp(REG_STATUS, 32'h00000041);
    conv_u.send(CH_REMOTE, 16'h0640);
    pins(1'b0, 1'b0, 1'b0);
    rd_cmp(REG_STATUS, 32'h000000A4);
    conv_u.send(CH_LOCAL, 16'h0190);
    wr(REG_CONFIG, 8'h04);
    rd_cmp(REG_CONFIG, 32'h00000004);
    rd_cmp(REG_LOCAL_RESULT, 32'h00001900);
    rd_cmp(REG_LOCAL_LOW_LIM, 32'h00000030);
    foreach (ext_t[i]) begin
      conv_u.send(CH_LOCAL, ext_t[i]);
      rd_cmp(REG_LOCAL_RESULT,
             fmt(RANGE_EXT, FMASK_SIXTEENTH, ext_t[i]));
      conv_u.send(CH_REMOTE, ext_t[i]);
      rd_cmp(REG_REMOTE_RESULT,
             fmt(RANGE_EXT, FMASK_SIXTEENTH, ext_t[i]));
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_cmp(REG_CONFIG, 32'h00000000);
    rd_cmp(REG_LOCAL_RESULT, 32'h00000000);
    conclude();
  end
endmodule
